/* File: tpc_pkg.sv */
// Constants, types and register layout for the interleave/iteration block
package tpc_pkg;
  // Register offsets (16-bit data, one register per index)
  localparam logic [1:0]  A_CFG     = 2'h0;
  localparam logic [1:0]  A_SLOPE   = 2'h1;
  localparam logic [1:0]  A_OFFS    = 2'h2;
  localparam logic [1:0]  A_CMD     = 2'h3;
  // Configuration field positions
  localparam int          B_DEC     = 0;
  localparam int          B_INTERLEAVE_ENABLE   = 1;
  localparam int          B_STOP    = 2;
  localparam int          B_PAR     = 3;
  localparam int          B_ITL     = 4;
  localparam int          ITL_W     = 5;
  // Command write and status read field positions
  localparam int          F_FLUSH   = 0;
  localparam int          F_DONE    = 0;
  localparam int          F_CORR    = 1;
  localparam int          F_BUSY    = 2;
  localparam int          F_NIT     = 3;
  // Reset values
  localparam logic [15:0] CFG_RST   = 16'h0030;
  localparam logic [15:0] SLOPE_RST = 16'h00D7;
  localparam logic [15:0] OFFS_RST  = 16'h0022;
  // Idle clocks after each deinterleaved input value
  localparam logic [1:0]  PACE_DEINT = 2'h2;
  // Axis iterations still to finish once a flush is armed
  localparam logic [1:0]  FLUSH_AXES = 2'h2;
  // Parallel output width
  localparam int          PAR_W     = 8;

  typedef enum logic [2:0] {
    E_IDLE = 3'b001,
    E_ITER = 3'b010,
    E_TAIL = 3'b100
  } eng_state_t;

  // Position on a helical diagonal: cell and start column
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    logic [7:0] sx;
  } diag_pos_t;

  // Register port request
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
endpackage : tpc_pkg

/* File: tpc_iter_buf.sv */
// Ping-pong buffers, helical interleave and iteration control
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
module tpc_iter_buf #(
  parameter int NX   = 64,
  parameter int NY   = 64,
  parameter int NZ   = 1,
  parameter int SW   = 4,
  parameter int AXES = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Register port
  input  wire tpc_pkg::reg_req_t reg_req,
  output logic [15:0]           reg_rdata,
  // Input stream
  input  wire logic             in_valid,
  input  wire logic [SW-1:0]    in_data,
  output logic                  in_accept,
  // Correction report from the soft-decision engine
  input  wire logic             axis_corr,
  // Output stream
  output logic                  output_ready,
  input  wire logic             output_accept,
  output logic [7:0]            output_data_bus,
  // Status flags
  output logic                  block_done_flag,
  output logic                  corrections_seen_flag
);
  localparam int BLK = NX * NY * NZ;
  localparam int AW  = $clog2(BLK);

  // Next cell on a diagonal; a new start column when it is complete
  function automatic tpc_pkg::diag_pos_t diag_next(
    input tpc_pkg::diag_pos_t p);
    tpc_pkg::diag_pos_t n;
    logic               yw;
    logic               zw;
    n  = p;
    yw = (p.y == 8'(NY - 1));
    zw = yw && (p.z == 8'(NZ - 1));
    n.x = (p.x == 8'(NX - 1)) ? 8'h00 : p.x + 8'h01;
    n.y = yw ? 8'h00 : p.y + 8'h01;
    if (yw) begin
      n.z = zw ? 8'h00 : p.z + 8'h01;
    end
    if (zw) begin
      n.sx = (p.sx == 8'(NX - 1)) ? 8'h00 : p.sx + 8'h01;
      n.x  = n.sx;
    end
    return n;
  endfunction : diag_next

  // Row-order cell index of a diagonal position
  function automatic logic [AW-1:0] cell_of(input tpc_pkg::diag_pos_t p);
    return AW'((32'(p.z) * NY + 32'(p.y)) * NX + 32'(p.x));
  endfunction : cell_of

  logic [SW-1:0]          in_ram [2*BLK];
  logic                   out_ram [2*BLK];
  logic [15:0]            cfg_ff;
  logic [15:0]            slope_ff;
  logic [15:0]            offs_ff;
  logic                   dec;
  logic                   deint;
  logic                   interleave_enable_out;
  localparam int ITL_W_L = tpc_pkg::ITL_W;
  logic [ITL_W_L-1:0]     lim;
  logic [1:0]             in_full_ff;
  logic [1:0]             out_full_ff;
  logic                   in_wsel_ff;
  logic                   eng_sel_ff;
  logic                   out_wsel_ff;
  logic                   out_rsel_ff;
  logic [AW-1:0]          in_cnt_ff;
  tpc_pkg::diag_pos_t     in_pos_ff;
  logic                   gap_ff;
  logic [1:0]             pace_ff;
  logic                   in_take;
  logic                   in_last;
  tpc_pkg::eng_state_t    state_ff;
  logic [15:0]            axis_cnt_ff;
  logic [15:0]            tail_cnt_ff;
  logic [15:0]            axis_len;
  logic [7:0]             axis_idx_ff;
  logic [ITL_W_L-1:0]     iters_ff;
  logic [1:0]             flush_cnt_ff;
  logic                   axis_hit_ff;
  logic                   iter_hit_ff;
  logic                   last_hit_ff;
  logic [AW:0]            cc_ff;
  logic                   copy_done;
  logic                   eng_start;
  logic                   axis_end;
  logic                   full_end;
  logic                   axis_hit;
  logic                   stop_now;
  logic                   finish;
  logic [AW:0]            ocnt_ff;
  tpc_pkg::diag_pos_t     opos_ff;
  logic                   par_out;
  logic                   ld;
  logic [AW:0]            ostep;
  logic [7:0]             par_byte;
  logic [AW-1:0]          oaddr;

  // Mode decode; one enable covers both directions
  // shared enable select
  assign dec       = cfg_ff[tpc_pkg::B_DEC];
  assign deint     = dec && cfg_ff[tpc_pkg::B_INTERLEAVE_ENABLE];
  assign interleave_enable_out = !dec && cfg_ff[tpc_pkg::B_INTERLEAVE_ENABLE];
  assign par_out   = dec && cfg_ff[tpc_pkg::B_PAR];
  assign lim = !dec ? ITL_W_L'(1) :
               (cfg_ff[tpc_pkg::B_ITL +: ITL_W_L] == '0) ? ITL_W_L'(1) :
               cfg_ff[tpc_pkg::B_ITL +: ITL_W_L];

  // Register writes; command bits act in the engine and flag logic
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff   <= tpc_pkg::CFG_RST;
      slope_ff <= tpc_pkg::SLOPE_RST;
      offs_ff  <= tpc_pkg::OFFS_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == tpc_pkg::A_CFG) begin
        cfg_ff <= reg_req.wdata;
      end else if (reg_req.addr == tpc_pkg::A_SLOPE) begin
        slope_ff <= reg_req.wdata;
      end else if (reg_req.addr == tpc_pkg::A_OFFS) begin
        offs_ff <= reg_req.wdata;
      end
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_req.rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.addr == tpc_pkg::A_CFG) begin
      reg_rdata <= cfg_ff;
    end else if (reg_req.addr == tpc_pkg::A_SLOPE) begin
      reg_rdata <= slope_ff;
    end else if (reg_req.addr == tpc_pkg::A_OFFS) begin
      reg_rdata <= offs_ff;
    end else begin
      reg_rdata <= {8'h00, iters_ff, state_ff != tpc_pkg::E_IDLE,
                    corrections_seen_flag, block_done_flag};
    end
  end

  // Input acceptance: free half, block gap and deinterleave pacing
  // full halves stall input
  assign in_accept = !in_full_ff[in_wsel_ff] && !gap_ff && pace_ff == 2'h0;
  assign in_take   = in_accept && in_valid;
  assign in_last   = in_cnt_ff == AW'(BLK - 1);

  // Input half loading
  // load one half
  always_ff @(posedge clk) begin
    if (rst) begin
      in_cnt_ff  <= '0;
      in_pos_ff  <= '0;
      in_wsel_ff <= 1'b0;
      gap_ff     <= 1'b0;
      pace_ff    <= 2'h0;
    end else begin
      gap_ff  <= in_take && in_last;
      pace_ff <= (in_take && deint) ? tpc_pkg::PACE_DEINT :
                 (pace_ff != 2'h0) ? pace_ff - 2'h1 : 2'h0;
      if (in_take) begin
        in_cnt_ff <= in_last ? '0 : in_cnt_ff + AW'(1);
        in_pos_ff <= in_last ? '0 : diag_next(in_pos_ff);
        if (in_last) begin
          in_wsel_ff <= !in_wsel_ff;
        end
      end
    end
  end

  // Input storage; deinterleaving rebuilds row order on the way in
  // same diagonal sequence
  always_ff @(posedge clk) begin
    if (in_take) begin
      in_ram[{in_wsel_ff, deint ? cell_of(in_pos_ff) : in_cnt_ff}] <= in_data;
    end
  end

  // Engine timing: axis iterations, then the fixed tail
  assign axis_len  = (slope_ff / 16'(AXES) == 16'h0000) ? 16'h0001 :
                     slope_ff / 16'(AXES);
  assign eng_start = state_ff == tpc_pkg::E_IDLE && in_full_ff[eng_sel_ff]
                     && !out_full_ff[out_wsel_ff];
  assign axis_end  = state_ff == tpc_pkg::E_ITER
                     && axis_cnt_ff == axis_len - 16'h0001;
  assign full_end  = axis_end && axis_idx_ff == 8'(AXES - 1);
  assign axis_hit  = axis_hit_ff || axis_corr;
  assign stop_now  = (full_end && iters_ff + ITL_W_L'(1) >= lim)
                     || (full_end && dec && cfg_ff[tpc_pkg::B_STOP]
                         && !(iter_hit_ff || axis_hit))
                     || (axis_end && flush_cnt_ff == 2'h1);
  assign copy_done = cc_ff == (AW + 1)'(BLK);
  assign finish    = state_ff == tpc_pkg::E_TAIL && copy_done
                     && tail_cnt_ff + 16'h0001 >= offs_ff;

  // Engine state and counters
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff     <= tpc_pkg::E_IDLE;
      axis_cnt_ff  <= 16'h0000;
      tail_cnt_ff  <= 16'h0000;
      axis_idx_ff  <= 8'h00;
      iters_ff     <= '0;
      flush_cnt_ff <= 2'h0;
      axis_hit_ff  <= 1'b0;
      iter_hit_ff  <= 1'b0;
      last_hit_ff  <= 1'b0;
    end else begin
      case (state_ff)
        tpc_pkg::E_IDLE: begin
          axis_cnt_ff  <= 16'h0000;
          axis_idx_ff  <= 8'h00;
          flush_cnt_ff <= 2'h0;
          axis_hit_ff  <= 1'b0;
          iter_hit_ff  <= 1'b0;
          if (eng_start) begin
            iters_ff <= '0;
            state_ff <= tpc_pkg::E_ITER;
          end
        end
        tpc_pkg::E_ITER: begin
          axis_hit_ff <= axis_end ? 1'b0 : axis_hit;
          axis_cnt_ff <= axis_end ? 16'h0000 : axis_cnt_ff + 16'h0001;
          if (axis_end) begin
            axis_idx_ff <= full_end ? 8'h00 : axis_idx_ff + 8'h01;
            iter_hit_ff <= full_end ? 1'b0 : iter_hit_ff || axis_hit;
            if (full_end) begin
              iters_ff <= iters_ff + ITL_W_L'(1);
            end
            if (flush_cnt_ff != 2'h0) begin
              flush_cnt_ff <= flush_cnt_ff - 2'h1;
            end
          end
          // A flush landing on an axis end counts that axis as done
          if (reg_req.wr && reg_req.addr == tpc_pkg::A_CMD && dec
              && reg_req.wdata[tpc_pkg::F_FLUSH]
              && flush_cnt_ff == 2'h0) begin
            flush_cnt_ff <= axis_end ? tpc_pkg::FLUSH_AXES - 2'h1
                                     : tpc_pkg::FLUSH_AXES;
          end
          if (stop_now) begin
            last_hit_ff <= axis_hit;
            tail_cnt_ff <= 16'h0000;
            state_ff    <= tpc_pkg::E_TAIL;
          end
        end
        tpc_pkg::E_TAIL: begin
          tail_cnt_ff <= tail_cnt_ff + 16'h0001;
          if (finish) begin
            state_ff <= tpc_pkg::E_IDLE;
          end
        end
        default: state_ff <= tpc_pkg::E_IDLE;
      endcase
    end
  end

  // Copy of the block into the output half, row order
  always_ff @(posedge clk) begin
    if (rst || eng_start) begin
      cc_ff <= '0;
    end else if (state_ff != tpc_pkg::E_IDLE && !copy_done) begin
      cc_ff <= cc_ff + (AW + 1)'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (state_ff != tpc_pkg::E_IDLE && !copy_done) begin
      out_ram[{out_wsel_ff, cc_ff[AW-1:0]}] <=
        dec ? in_ram[{eng_sel_ff, cc_ff[AW-1:0]}][SW-1]
            : in_ram[{eng_sel_ff, cc_ff[AW-1:0]}][0];
    end
  end

  // Half ownership; a flushed block is passed on like any other
  // forward then next block
  always_ff @(posedge clk) begin
    if (rst) begin
      in_full_ff  <= 2'b00;
      out_full_ff <= 2'b00;
      eng_sel_ff  <= 1'b0;
      out_wsel_ff <= 1'b0;
      out_rsel_ff <= 1'b0;
    end else begin
      if (in_take && in_last) begin
        in_full_ff[in_wsel_ff] <= 1'b1;
      end
      if (finish) begin
        in_full_ff[eng_sel_ff]   <= 1'b0;
        out_full_ff[out_wsel_ff] <= 1'b1;
        eng_sel_ff  <= !eng_sel_ff;
        out_wsel_ff <= !out_wsel_ff;
      end
      if (ld && ocnt_ff + ostep >= (AW + 1)'(BLK)) begin
        out_full_ff[out_rsel_ff] <= 1'b0;
        out_rsel_ff <= !out_rsel_ff;
      end
    end
  end

  // Sticky flags: hardware set wins over a write-one clear
  // done and corrections flags
  always_ff @(posedge clk) begin
    if (rst) begin
      block_done_flag       <= 1'b0;
      corrections_seen_flag <= 1'b0;
    end else begin
      block_done_flag <= finish || (block_done_flag && !(reg_req.wr
        && reg_req.addr == tpc_pkg::A_CMD && reg_req.wdata[tpc_pkg::F_DONE]));
      corrections_seen_flag <= (finish && last_hit_ff)
        || (corrections_seen_flag && !(reg_req.wr
        && reg_req.addr == tpc_pkg::A_CMD && reg_req.wdata[tpc_pkg::F_CORR]));
    end
  end

  // Output source: byte gather, diagonal read or row-order read
  genvar g;
  generate
    for (g = 0; g < tpc_pkg::PAR_W; g++) begin : g_byte
      assign par_byte[g] =
        out_ram[{out_rsel_ff, AW'(ocnt_ff[AW-1:0] + AW'(g))}];
    end
  endgenerate
  assign oaddr = interleave_enable_out ? cell_of(opos_ff) : ocnt_ff[AW-1:0];
  assign ostep = par_out ? (AW + 1)'(tpc_pkg::PAR_W) : (AW + 1)'(1);
  assign ld    = out_full_ff[out_rsel_ff] && (!output_ready || output_accept);

  // Output unload
  // diagonal walk
  always_ff @(posedge clk) begin
    if (rst) begin
      ocnt_ff         <= '0;
      opos_ff         <= '0;
      output_ready    <= 1'b0;
      output_data_bus <= 8'h00;
    end else if (ld) begin
      output_ready    <= 1'b1;
      output_data_bus <= par_out ? par_byte
                                 : {7'h00, out_ram[{out_rsel_ff, oaddr}]};
      if (ocnt_ff + ostep >= (AW + 1)'(BLK)) begin
        ocnt_ff <= '0;
        opos_ff <= '0;
      end else begin
        ocnt_ff <= ocnt_ff + ostep;
        opos_ff <= diag_next(opos_ff);
      end
    end else if (output_accept) begin
      output_ready <= 1'b0;
    end
  end

  a_block_gap: assert property (@(posedge clk) disable iff (rst)
    in_take && in_last |=> !in_accept)
    else $error("input accepted right after block end");
  a_deint_pace: assert property (@(posedge clk) disable iff (rst)
    in_take && deint |=> !in_accept ##1 !in_accept)
    else $error("deinterleave pacing broken");
  a_input_stall: assert property (@(posedge clk) disable iff (rst)
    in_full_ff == 2'b11 |-> !in_accept)
    else $error("input accepted with both halves loaded");
  a_iter_limit: assert property (@(posedge clk) disable iff (rst)
    state_ff == tpc_pkg::E_TAIL |-> iters_ff <= lim)
    else $error("iteration limit exceeded");
  a_early_stop: assert property (@(posedge clk) disable iff (rst)
    full_end && dec && cfg_ff[tpc_pkg::B_STOP] && !iter_hit_ff && !axis_hit
    |=> state_ff == tpc_pkg::E_TAIL)
    else $error("clean iteration did not stop decoding");
  a_flush_stop: assert property (@(posedge clk) disable iff (rst)
    axis_end && flush_cnt_ff == 2'h1 |=> state_ff == tpc_pkg::E_TAIL)
    else $error("flush did not end iterations");
  a_done_flag: assert property (@(posedge clk) disable iff (rst)
    finish |=> block_done_flag && !in_full_ff[!eng_sel_ff])
    else $error("finish did not flag or free the half");
  a_out_hold: assert property (@(posedge clk) disable iff (rst)
    output_ready && !output_accept |=> output_ready
    && $stable(output_data_bus))
    else $error("output changed without accept");
  a_enc_serial: assert property (@(posedge clk) disable iff (rst)
    output_ready && !par_out |-> output_data_bus[7:1] == 7'h00)
    else $error("serial output uses upper bits");
endmodule : tpc_iter_buf

/* File: tpc_sink.sv */
// Downstream consumer model for the output stream
`timescale 1ns/1ns
module tpc_sink (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Output stream from the block
  input  wire logic       output_ready,
  input  wire logic [7:0] output_data_bus,
  output logic            output_accept,
  // Pacing: 0 prompt, 1 every other clock, 2 stalled
  input  wire logic [1:0] mode
);
  logic [7:0] words[$];
  logic       tog_ff;

  // Toggle for the slow accept pattern
  always_ff @(posedge clk) begin
    if (rst) begin
      tog_ff <= 1'b0;
    end else begin
      tog_ff <= ~tog_ff;
    end
  end

  // Accept level as chosen by the bench
  assign output_accept = !rst && (mode == 2'h0 || (mode == 2'h1 && tog_ff));

  always @(posedge clk) begin
    if (!rst && output_ready && output_accept) begin
      words.push_back(output_data_bus);
    end
  end
endmodule : tpc_sink

/* File: tb_top.sv */
// Self-checking bench for the interleave and iteration block
`timescale 1ns/1ns
module tb_top;
  localparam int          NX  = 4;
  localparam int          NY  = 4;
  localparam int          BLK = NX * NY;
  localparam logic [15:0] PAT = 16'hB4E1;
  logic                   clk;
  logic                   rst;
  tpc_pkg::reg_req_t      req;
  logic [15:0]            rdata;
  logic                   in_valid;
  logic [3:0]             in_data;
  logic                   in_accept;
  logic                   axis_corr;
  logic                   output_ready;
  logic                   output_accept;
  logic [7:0]             output_data_bus;
  logic                   done;
  logic                   corr;
  logic [1:0]             mode;
  logic [7:0]             exq[$];
  logic [15:0]            st;
  int                     num_errors;
  int                     compares;
  int                     cyc;
  int                     got;

  tpc_iter_buf #(.NX(NX), .NY(NY), .NZ(1), .SW(4), .AXES(2)) tpc_iter_buf_i (
    .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
    .in_valid(in_valid), .in_data(in_data), .in_accept(in_accept),
    .axis_corr(axis_corr), .output_ready(output_ready),
    .output_accept(output_accept), .output_data_bus(output_data_bus),
    .block_done_flag(done), .corrections_seen_flag(corr));
  tpc_sink tpc_sink_i (.clk(clk), .rst(rst), .output_ready(output_ready),
    .output_data_bus(output_data_bus), .output_accept(output_accept),
    .mode(mode));

  // Clock and cycle count
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd

  // Row-order cell of the k-th value on a down-right diagonal
  function automatic int diag(input int k);
    return (k % NY) * NX + (k / NY + k % NY) % NX;
  endfunction : diag

  // Source: one block after another, spacing checked at each take
  task automatic feed(input int nblk, input bit dec, input bit intl,
                      output int n);
    int t0;
    int w;
    int c;
    int step;
    n = 0;
    t0 = -9;
    step = (dec && intl) ? 3 : 1;
    for (int k = 0; k < nblk * BLK; k++) begin
      c = (dec && intl) ? diag(k % BLK) : k % BLK;
      in_valid <= 1'b1;
      in_data <= dec ? {PAT[c], 3'h0} : {3'h0, PAT[c]};
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!in_accept && w < 300);
      if (!in_accept) begin
        in_valid <= 1'b0;
        chk("input timeout", 16'h0001, 16'h0000);
        conclude();
        return;
      end
      n++;
      if (k % BLK != 0) chk("input spacing", 16'(step), 16'(cyc - t0));
      else chk("block gap", 16'h0001, 16'(cyc - t0 >= 2));
      t0 = cyc;
    end
    in_valid <= 1'b0;
  endtask : feed

  // Expected words of one block
  task automatic expect_blk(input bit dec, input bit intl, input bit par);
    for (int k = 0; k < BLK; k++) begin
      if (par && k % 8 == 0) exq.push_back(PAT[k +: 8]);
      else if (!par) exq.push_back({7'h00, PAT[(!dec && intl) ? diag(k) : k]});
    end
  endtask : expect_blk

  // Wait for all expected words, then compare
  task automatic drain();
    int w;
    w = 0;
    while (tpc_sink_i.words.size() < exq.size() && w < 3000) begin
      @(posedge clk);
      w++;
    end
    if (w == 3000) begin
      chk("drain timeout", 16'h0001, 16'h0000);
      conclude();
    end
    repeat (4) @(posedge clk);
    chk("word count", 16'(exq.size()), 16'(tpc_sink_i.words.size()));
    foreach (exq[i]) chk("output word", {8'h00, exq[i]},
                         {8'h00, tpc_sink_i.words[i]});
    exq.delete();
    tpc_sink_i.words.delete();
  endtask : drain

  task automatic run(input logic [15:0] cfg, input int nblk);
    wr(tpc_pkg::A_CFG, cfg);
    feed(nblk, cfg[0], cfg[1], got);
    chk("values taken", 16'(nblk * BLK), 16'(got));
    repeat (nblk) expect_blk(cfg[0], cfg[1], cfg[3]);
    drain();
  endtask : run

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    in_valid = 1'b0;
    in_data = 4'h0;
    axis_corr = 1'b0;
    mode = 2'h0;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(tpc_pkg::A_CFG, st);
    chk("cfg reset", 16'h0030, st);
    rd(tpc_pkg::A_SLOPE, st);
    chk("slope reset", 16'h00D7, st);
    rd(tpc_pkg::A_OFFS, st);
    chk("offset reset", 16'h0022, st);
    rd(tpc_pkg::A_CMD, st);
    chk("status reset", 16'h0000, st);
    wr(tpc_pkg::A_SLOPE, 16'h0008);
    wr(tpc_pkg::A_OFFS, 16'h0004);
    $display("test registers done");
    run(16'h0010, 2);
    $display("test plain encode done");
    mode <= 2'h1;
    run(16'h0012, 1);
    mode <= 2'h0;
    $display("test interleaved encode done");
    axis_corr <= 1'b1;
    run(16'h0033, 1);
    rd(tpc_pkg::A_CMD, st);
    chk("iteration count", 16'h0003, 16'(st[7:3]));
    wr(tpc_pkg::A_CMD, 16'h0003);
    chk("flags cleared", 16'h0000, {14'h0, done, corr});
    $display("test deinterleaved decode done");
    axis_corr <= 1'b0;
    run(16'h005D, 2);
    rd(tpc_pkg::A_CMD, st);
    chk("early stop count", 16'h0001, 16'(st[7:3]));
    chk("done no corr", 16'h0002, {14'h0, done, corr});
    wr(tpc_pkg::A_CMD, 16'h0003);
    $display("test early stop done");
    axis_corr <= 1'b1;
    wr(tpc_pkg::A_CFG, 16'h01F1);
    feed(1, 1'b1, 1'b0, got);
    chk("values taken", 16'(BLK), 16'(got));
    @(posedge clk);
    wr(tpc_pkg::A_CMD, 16'h0001);
    expect_blk(1'b1, 1'b0, 1'b0);
    drain();
    rd(tpc_pkg::A_CMD, st);
    chk("flush cut short", 16'h0001, 16'(st[7:3] <= 5'h02));
    chk("flush flags", 16'h0003, {14'h0, done, corr});
    wr(tpc_pkg::A_CMD, 16'h0003);
    axis_corr <= 1'b0;
    $display("test flush done");
    mode <= 2'h2;
    wr(tpc_pkg::A_CFG, 16'h0010);
    feed(4, 1'b0, 1'b0, got);
    chk("stalled intake", 16'(4 * BLK), 16'(got));
    // Both halves now hold blocks: intake must stay shut
    got = 0;
    repeat (50) begin
      @(posedge clk);
      if (in_accept !== 1'b0) got++;
    end
    chk("input stall", 16'h0000, 16'(got));
    mode <= 2'h0;
    repeat (4) expect_blk(1'b0, 1'b0, 1'b0);
    drain();
    $display("test output stall done");
    conclude();
  end
endmodule : tb_top
